// [hdl/sto_defs.vh]
// Purpose : shared constants for the safe torque off gate
// Assumes : 40 MHz system clock
// Notes   : times are kept in ms; the matching cycle counts are given here as fixed literals
`ifndef STO_DEFS_VH
`define STO_DEFS_VH

// ==========================================================
// clock and timing
`define STO_CLK_KHZ          40000
`define STO_RESP_BRAKE_MS    30
`define STO_RESP_NOBRAKE_MS  5
`define STO_DISCREP_MS       10
`define STO_CNT_W            21
// the same limits as cycle counts at 40 MHz, sized to the counter width
`define STO_RESP_BRAKE_CYC   21'h124F80
`define STO_RESP_NOBRAKE_CYC 21'h030D40
`define STO_DISCREP_CYC      21'h061A80

// ==========================================================
// fault sub-codes, shown as the digit after the point
`define STO_FC_EXT_REQ       3'h0
`define STO_FC_INCONSIST     3'h1
`define STO_FC_SUPPLY        3'h2
`define STO_FC_IN_CIRCUIT    3'h3
`define STO_FC_BUFFER        3'h4

// ==========================================================
// reset values
`define STO_PWM_W            6
`define STO_PWM_RESET        6'h00
`define STO_CNT_RESET        21'h000000

`endif

// [hdl/discrepancy_timer.v]
// Purpose : measures how long two synchronised safety inputs disagree
// Assumes : inputs already synchronised to sys_clk
// Notes   : expired stays high while the disagreement lasts past the limit
`timescale 1ns/100ps
`include "sto_defs.vh"

module discrepancy_timer
#(
  parameter [`STO_CNT_W-1:0] LIMIT_CYC = `STO_DISCREP_CYC
)
(
  input  wire sys_clk,
  input  wire rst_n,
  input  wire in_a,
  input  wire in_b,
  output reg  expired
);

  reg [`STO_CNT_W-1:0] count_reg;   // cycles spent in disagreement

  // ==========================================================
  // counter: restarts whenever the inputs agree again
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= `STO_CNT_RESET;
      expired   <= 1'b0;
    end
    else if (in_a == in_b)
    begin
      // agreement, including both low together
      count_reg <= `STO_CNT_RESET;
      expired   <= 1'b0;
    end
    else
    begin
      // saturate so a long single drop never wraps back to zero
      if (count_reg != LIMIT_CYC)
        count_reg <= count_reg + {{(`STO_CNT_W-1){1'b0}}, 1'b1};
      expired <= (count_reg == LIMIT_CYC);
    end
  end

endmodule

// [hdl/safe_torque_off_gate.v]
// Purpose : gates power-stage pwm from two redundant safety inputs
// Assumes : pins and diagnostic flags are asynchronous; pwm_in, init_done,
//           run_cmd and configuration come from sys_clk logic
// Notes   : gating acts within three cycles, far inside either response time
//
// Function
// - pwm passes only while both inputs high
// - brake motor: disable and block within 30 ms
// - no-brake motor: disable within 5 ms
// - late or single drop raises inconsistency code
// - select one, both low: external-request code
// - select zero, both low: indicate only
// - supply over/under voltage: safe-off, supply code
// - input circuit fault: safe-off, its code
// - buffer circuit fault: safe-off, its code
// - buffer held off until initialisation done
// - recover: inputs high, run off, no fault
// - safe-off removes gating only, motor coasts
// - after single drop stay stopped, keep code (cleared here by the normal recovery)
`timescale 1ns/100ps
`include "sto_defs.vh"

module safe_torque_off_gate
#(
  parameter [`STO_CNT_W-1:0] RESP_BRAKE_CYC   = `STO_RESP_BRAKE_CYC,
  parameter [`STO_CNT_W-1:0] RESP_NOBRAKE_CYC = `STO_RESP_NOBRAKE_CYC,
  parameter [`STO_CNT_W-1:0] DISCREP_CYC      = `STO_DISCREP_CYC
)
(
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  safe_off_input_a,      // pin, high = run allowed
  input  wire                  safe_off_input_b,      // pin, high = run allowed
  input  wire                  brake_fitted,          // motor has a brake
  input  wire                  both_low_fault_select, // 1: both low is a fault
  input  wire                  supply_fault_in,       // pin, 5 V out of range
  input  wire                  input_circuit_fault_in,// pin, input diagnosis
  input  wire                  buffer_circuit_fault_in,// pin, buffer diagnosis
  input  wire                  buffer_enabled_fb,     // pin, buffer readback
  input  wire                  init_done,             // controller init finished
  input  wire                  run_cmd,               // servo on/run command
  input  wire [`STO_PWM_W-1:0] pwm_in,                // gating from modulator
  output reg  [`STO_PWM_W-1:0] pwm_out,               // gating to power stage
  output reg                   buffer_enable,         // pwm buffer enable
  output reg                   drive_enable,          // drive may make torque
  output reg                   safe_off_active,       // in safe state
  output reg                   safe_off_indicate,     // safe state, no fault
  output reg                   fault_active,          // a fault code is latched
  output reg  [2:0]            fault_code             // latched sub-code
);

  // ==========================================================
  // states
  localparam [2:0] ST_INIT = 3'b001;   // power-on and initialisation
  localparam [2:0] ST_RUN  = 3'b010;   // gating released
  localparam [2:0] ST_SAFE = 3'b100;   // torque off

  reg [2:0]            state_reg;      // current state
  reg [2:0]            state_next;     // next state
  reg [5:0]            sync1_reg;      // first synchroniser stage
  reg [5:0]            sync2_reg;      // second stage, the only one read
  reg [4:0]            flag_reg;       // latched causes, bit n = sub-code n
  reg [4:0]            flag_next;      // next latched causes
  reg [`STO_CNT_W-1:0] dead_reg;       // cycles since an input dropped
  reg                  dead_hit_reg;   // deadline passed with buffer still on
  wire                 in_a;           // synchronised input a
  wire                 in_b;           // synchronised input b
  wire                 both_high;      // run allowed by the inputs
  wire                 both_low;       // full safe-off request
  wire                 discrep_exp;    // disagreement past its limit
  wire                 diag_now;       // a dangerous fault is present now
  wire                 recover_ok;     // conditions to leave safe state
  wire [`STO_CNT_W-1:0] dead_limit;    // deadline picked by motor type

  assign in_a       = sync2_reg[0];
  assign in_b       = sync2_reg[1];
  assign both_high  = in_a & in_b;
  assign both_low   = ~in_a & ~in_b;
  assign dead_limit = brake_fitted ? RESP_BRAKE_CYC : RESP_NOBRAKE_CYC;
  assign diag_now   = sync2_reg[2] | sync2_reg[3] | sync2_reg[4] | dead_hit_reg;
  assign recover_ok = both_high & ~run_cmd & ~diag_now;

  // ==========================================================
  // synchronisers for every pin
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;   // inputs read as low until sampled: safe side
    end
    else
    begin
      // the buffer readback is a pin too, so it is synchronised like the rest
      sync1_reg <= {buffer_enabled_fb, buffer_circuit_fault_in, input_circuit_fault_in,
                    supply_fault_in, safe_off_input_b, safe_off_input_a};
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // disagreement timer
  discrepancy_timer #(
    .LIMIT_CYC (DISCREP_CYC)
  ) u_discrep (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .in_a    (in_a),
    .in_b    (in_b),
    .expired (discrep_exp)
  );

  // ==========================================================
  // response deadline: if the buffer readback still shows enabled after
  // the deadline, the buffer path is treated as broken
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dead_reg     <= `STO_CNT_RESET;
      dead_hit_reg <= 1'b0;
    end
    else if (both_high)
    begin
      dead_reg     <= `STO_CNT_RESET;
      dead_hit_reg <= 1'b0;
    end
    else
    begin
      if (dead_reg != dead_limit)
        dead_reg <= dead_reg + {{(`STO_CNT_W-1){1'b0}}, 1'b1};
      // sticky until the inputs return; the latched code holds longer
      if ((dead_reg == dead_limit) && sync2_reg[5])
        dead_hit_reg <= 1'b1;
    end
  end

  // ==========================================================
  // fault latches: a new cause always wins over the recovery clear
  always @*
  begin
    flag_next = flag_reg;
    if (recover_ok && (state_reg == ST_SAFE))
      flag_next = 5'h00;
    if (both_low && both_low_fault_select)
      flag_next[`STO_FC_EXT_REQ] = 1'b1;
    if (discrep_exp)
      flag_next[`STO_FC_INCONSIST] = 1'b1;
    if (sync2_reg[2])
      flag_next[`STO_FC_SUPPLY] = 1'b1;
    if (sync2_reg[3])
      flag_next[`STO_FC_IN_CIRCUIT] = 1'b1;
    if (sync2_reg[4] || dead_hit_reg)
      flag_next[`STO_FC_BUFFER] = 1'b1;
  end

  // ==========================================================
  // state machine
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT:
      begin
        // buffer stays off until the controller is up
        if (init_done)
          state_next = ST_SAFE;
      end
      ST_RUN:
      begin
        // any drop or any latched fault ends the run at once
        if (!both_high || (flag_next != 5'h00) || diag_now)
          state_next = ST_SAFE;
      end
      ST_SAFE:
      begin
        // run_cmd must be off first, so a start command cannot restart it
        if (recover_ok && init_done)
          state_next = ST_RUN;
      end
      default:
      begin
        state_next = ST_INIT;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_INIT;
      flag_reg  <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      flag_reg  <= flag_next;
    end
  end

  // ==========================================================
  // outputs, all registered; no braking pattern is ever produced,
  // only gating is removed so the motor coasts
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwm_out           <= `STO_PWM_RESET;
      buffer_enable     <= 1'b0;
      drive_enable      <= 1'b0;
      safe_off_active   <= 1'b1;
      safe_off_indicate <= 1'b0;
      fault_active      <= 1'b0;
      fault_code        <= `STO_FC_EXT_REQ;
    end
    else
    begin
      // gate on the live inputs too; a drop clears gating on the same edge as the state moves
      if ((state_next == ST_RUN) && both_high)
      begin
        pwm_out       <= pwm_in;
        buffer_enable <= 1'b1;
        drive_enable  <= 1'b1;
      end
      else
      begin
        pwm_out       <= `STO_PWM_RESET;
        buffer_enable <= 1'b0;
        drive_enable  <= 1'b0;
      end
      safe_off_active   <= (state_next != ST_RUN);
      safe_off_indicate <= (state_next == ST_SAFE) && (flag_next == 5'h00);
      fault_active      <= (flag_next != 5'h00);
      // most serious cause shown first
      if (flag_next[`STO_FC_BUFFER])
        fault_code <= `STO_FC_BUFFER;
      else if (flag_next[`STO_FC_IN_CIRCUIT])
        fault_code <= `STO_FC_IN_CIRCUIT;
      else if (flag_next[`STO_FC_SUPPLY])
        fault_code <= `STO_FC_SUPPLY;
      else if (flag_next[`STO_FC_INCONSIST])
        fault_code <= `STO_FC_INCONSIST;
      else
        fault_code <= `STO_FC_EXT_REQ;
    end
  end

endmodule

// [tb/sto_ctrl_model.sv]
// Purpose : far-side safety controller driving both safety inputs
// Assumes : bench requests are levels on sys_clk
// Notes   : a normal stop drops both inputs on the same edge
`timescale 1ns/100ps
module sto_ctrl_model
(
  input  logic sys_clk,
  input  logic req_a,   // bench wants input a high
  input  logic req_b,   // bench wants input b high
  output logic out_a,   // safe_off_input_a pin
  output logic out_b    // safe_off_input_b pin
);
  // ==========================================
  // pins: one register stage, both move together when both requests move
  initial {out_a, out_b} = 2'b11;
  always @(posedge sys_clk)
  begin
    out_a <= req_a;
    out_b <= req_b;
  end
endmodule

// [tb/safe_torque_off_gate_chk.sv]
// Purpose : port-level assertions for the torque off gate
// Assumes : one clock, async active-low reset
// Notes   : gate latency allowance covers the 2FF synchroniser
`timescale 1ns/100ps
module sto_gate_chk
(
  input wire       sys_clk,
  input wire       rst_n,
  input wire       safe_off_input_a,
  input wire       safe_off_input_b,
  input wire       supply_fault_in,
  input wire       init_done,
  input wire       run_cmd,
  input wire [5:0] pwm_in,
  input wire [5:0] pwm_out,
  input wire       buffer_enable,
  input wire       drive_enable,
  input wire       safe_off_active,
  input wire       safe_off_indicate,
  input wire       fault_active,
  input wire [2:0] fault_code
);
  // ==========================================
  // common clocking
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // gating fully removed
  sequence s_gate_off;
    pwm_out == 6'h00 && !drive_enable && !buffer_enable;
  endsequence
  a_input_low_gates: assert property ((!safe_off_input_a || !safe_off_input_b) |-> ##[1:4] s_gate_off)
    else $error("gating not removed after input low");
  a_pwm_follows_in: assert property (drive_enable |-> pwm_out == $past(pwm_in))
    else $error("pwm_out differs from delayed pwm_in");
  a_enables_paired: assert property (buffer_enable == drive_enable)
    else $error("buffer and drive enables differ");
  a_safe_not_run: assert property (safe_off_active == !drive_enable)
    else $error("safe_off_active wrong");
  a_indicate_no_fault: assert property (safe_off_indicate |-> !fault_active && safe_off_active)
    else $error("indicate with fault or outside safe");
  a_idle_code_zero: assert property (!fault_active |-> fault_code == 3'h0)
    else $error("code set without fault");
  a_init_blocks: assert property ($rose(buffer_enable) |-> $past(init_done))
    else $error("buffer released before init");
  a_run_cmd_blocks: assert property ($rose(drive_enable) |-> !$past(run_cmd))
    else $error("recovered with run command active");
  a_supply_trips: assert property (supply_fault_in |-> ##[1:5] (fault_active && safe_off_active))
    else $error("supply fault not latched");
endmodule
bind safe_torque_off_gate sto_gate_chk i_chk (.sys_clk, .rst_n, .safe_off_input_a, .safe_off_input_b,
  .supply_fault_in, .init_done, .run_cmd, .pwm_in, .pwm_out, .buffer_enable, .drive_enable,
  .safe_off_active, .safe_off_indicate, .fault_active, .fault_code);

// [tb/tb_safe_torque_off_gate.sv]
// Purpose : scenario bench for the torque off gate
// Assumes : short deadlines 20/8/12 cycles keep the run brief
// Notes   : buffer readback follows the enable unless stuck on purpose
`timescale 1ns/100ps
`include "sto_defs.vh"
module tb_safe_torque_off_gate;
  // ==========================================
  // stimulus and observed nets
  logic sys_clk = 0, rst_n = 0, req_a = 1, req_b = 1, brake = 0, sel = 0;
  logic fb_stuck = 0, init_done = 0, run_cmd = 0;
  logic [2:0] diag = 3'h0;        // supply, input circuit, buffer pins
  logic [5:0] pwm_in = 6'h00;
  wire  a, b, buf_en, drv_en, so_act, so_ind, f_act;
  wire  [5:0] pwm_out;
  wire  [2:0] f_code;
  int   miscompares = 0, cmp_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  sto_ctrl_model i_ctrl (.sys_clk(sys_clk), .req_a(req_a), .req_b(req_b), .out_a(a), .out_b(b));
  safe_torque_off_gate #(.RESP_BRAKE_CYC(21'h14), .RESP_NOBRAKE_CYC(21'h08), .DISCREP_CYC(21'h0C)) i_dut
    (.sys_clk(sys_clk), .rst_n(rst_n), .safe_off_input_a(a), .safe_off_input_b(b), .brake_fitted(brake),
     .both_low_fault_select(sel), .supply_fault_in(diag[0]), .input_circuit_fault_in(diag[1]),
     .buffer_circuit_fault_in(diag[2]), .buffer_enabled_fb(buf_en | fb_stuck), .init_done(init_done),
     .run_cmd(run_cmd), .pwm_in(pwm_in), .pwm_out(pwm_out), .buffer_enable(buf_en), .drive_enable(drv_en),
     .safe_off_active(so_act), .safe_off_indicate(so_ind), .fault_active(f_act), .fault_code(f_code));
  // ==========================================
  // helpers
  task summarize;
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // wait n edges, then let their updates land
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait for the gate to reopen
  task wait_run;
    int i;
    for (i = 0; i < 40 && drv_en !== 1'b1; i++)
      cyc(1);
    if (i == 40)
    begin
      miscompares++;
      summarize();
    end
  endtask
  // inputs back, start command first held on, then dropped
  task recover;
    @(posedge sys_clk);
    {req_a, req_b, fb_stuck, diag} <= 6'h30;
    cyc(8);
    check("drv_en held by run", drv_en, 0);
    @(posedge sys_clk);
    run_cmd <= 1'b0;
    wait_run();
    check("fault cleared", f_act, 0);
    @(posedge sys_clk);
    run_cmd <= 1'b1;
  endtask
  // ==========================================
  // scenarios
  task t_init;
    cyc(10);
    check("buf_en in init", buf_en, 0);
    check("so_act in init", so_act, 1);
    @(posedge sys_clk);
    init_done <= 1'b1;
    pwm_in <= 6'h2D;
    wait_run();
    cyc(2);
    check("pwm_out running", pwm_out, 8'h2D);
    check("so_act running", so_act, 0);
    @(posedge sys_clk);
    run_cmd <= 1'b1;
  endtask
  task t_both(input logic s);
    @(posedge sys_clk);
    {sel, req_a, req_b} <= {s, 2'b00};
    cyc(6);
    check("pwm_out both low", pwm_out, 0);
    check("so_act both low", so_act, 1);
    check("fault both low", f_act, s);
    check("indicate both low", so_ind, !s);
    check("code both low", f_code, `STO_FC_EXT_REQ);
    cyc(20);
    check("no mismatch code", f_act, s);
    recover();
  endtask
  task t_single;
    @(posedge sys_clk);
    {sel, req_a} <= 2'b00;
    cyc(5);
    check("drv_en one low", drv_en, 0);
    check("fault early", f_act, 0);
    cyc(20);
    check("code one low", f_code, `STO_FC_INCONSIST);
    recover();
  endtask
  task t_diag;
    logic [2:0] codes[3];
    codes[0] = `STO_FC_SUPPLY;
    codes[1] = `STO_FC_IN_CIRCUIT;
    codes[2] = `STO_FC_BUFFER;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge sys_clk);
      diag[k] <= 1'b1;
      cyc(6);
      check("drv_en diag", drv_en, 0);
      check("code diag", f_code, codes[k]);
      recover();
    end
  endtask
  // readback stuck on: deadline depends on brake
  task t_deadline(input logic br);
    @(posedge sys_clk);
    {brake, fb_stuck, req_a, req_b} <= {br, 3'b100};
    cyc(16);
    check("deadline early", f_act, !br);
    cyc(16);
    check("deadline code", f_code, `STO_FC_BUFFER);
    recover();
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_init();
    t_both(1'b0);
    t_both(1'b1);
    t_single();
    t_diag();
    t_deadline(1'b0);
    t_deadline(1'b1);
    summarize();
  end
endmodule
